/* logic/tws_eeprom_slave.sv */
// two-wire memory target: serial sequencer, address counter, page buffer,
// self-timed commit engine with its fifo, and the byte array itself
// assumes scl, sda and the strap pins are asynchronous to core_clk and
// that the serial clock is much slower than core_clk
// How it works
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop, standby
// - eight bits msb first, ack ninth
// - standby at reset, and after stop once any self-timed write ends
// - start always recovers the sequencer
// - device word follows start, type nibble
// - three strap bits select the device
// - eighth bit: one read, zero write
// - match acks, mismatch returns to standby
// - write protect guards upper quarter
// - byte write: device, two addresses, data
// - self-timed write after stop, ignores bus
// - page write up to thirty-two bytes
// - write increments low five bits only
// - polling acked only once write ends
// - counter holds last address plus one
// - reads wrap across whole array
// - current read sends byte at counter
// - random read via dummy write address
// - master ack continues sequential read
// - array of 256 pages, 32 bytes
`timescale 1ns/1ns

// commit fifo between page buffer and array
module tws_fifo #(
    parameter int WIDTH = 21,     // entry width
    parameter int DEPTH = 16      // entry count, power of two
) (
    input wire logic core_clk,           // core clock
    input wire logic rst_n,              // async reset, active low
    input wire logic ce,                 // clock enable
    input wire logic inValid,            // fill side offers an entry
    output logic inReady,                // fifo has room
    input wire logic [WIDTH-1:0] inData, // entry in
    output logic outValid,               // fifo holds an entry
    input wire logic outReady,           // drain side takes the entry
    output logic [WIDTH-1:0] outData     // oldest entry
);
    localparam int PTR_W = $clog2(DEPTH);

    // refuse depths the pointer wrap cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("tws_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] store [DEPTH]; // entry storage
    logic [PTR_W-1:0] wrPtr;         // next slot to fill
    logic [PTR_W-1:0] rdPtr;         // oldest slot
    logic [PTR_W:0] fill;            // entries held
    logic doPush;                    // accepted push
    logic doPop;                     // accepted pop

    assign inReady = (fill != (PTR_W+1)'(DEPTH));
    assign outValid = (fill != '0);
    assign outData = store[rdPtr];
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    // storage write
    always_ff @(posedge core_clk)
    begin
        if (ce && doPush)
        begin
            store[wrPtr] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill <= '0;
        end
        else if (ce)
        begin
            if (doPush)
            begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop)
            begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPush && !doPop)
            begin
                fill <= fill + 1'b1;
            end
            else if (doPop && !doPush)
            begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule : tws_fifo

// top of the memory target
module tws_eeprom_slave #(
    parameter int WR_CYCLES_P = tws_pkg::WR_CYCLES, // self-timed write length
    parameter int FIFO_DEPTH_P = tws_pkg::FIFO_DEPTH // commit fifo depth
) (
    input wire logic core_clk,          // core clock, 20 MHz
    input wire logic rst_n,             // async reset, active low
    input wire logic ce,                // clock enable, freezes all state
    input wire logic sclPin,            // serial clock pin
    input wire logic sdaIn,             // serial data pin level
    output logic sdaOut,                // serial data drive value, always low
    output logic sdaOe,                 // high while pulling data low
    input wire logic wpPin,             // write protect pin
    input wire logic select_strap_bit2, // select strap, msb
    input wire logic select_strap_bit1, // select strap
    input wire logic select_strap_bit0, // select strap, lsb
    output logic standby,               // idle with no write pending
    output logic writeBusy              // self-timed write running
);
    import tws_pkg::*;

    localparam int TIMER_W = $clog2(WR_CYCLES_P + 1);

    // refuse a write cycle that could never elapse
    if (WR_CYCLES_P < 1) begin : g_bad_wr
        $error("tws_eeprom_slave write cycle count must be positive");
    end

    // synchronisers and edge history
    logic sclS1, sclS2, sclD;      // serial clock stages
    logic sdaS1, sdaS2, sdaD;      // serial data stages
    logic wpS1, wpS2;              // write protect stages
    logic [2:0] strapS1, strapS2;  // select strap stages
    // sequencer
    tws_state_t state;             // bus-side state
    logic [3:0] bitCnt;            // bit within the nine-clock word
    logic [7:0] shiftIn;           // received bits
    logic [7:0] txByte;            // byte being sent
    logic masterAck;               // master acked last read byte
    logic sdaPull;                 // registered drive enable
    logic seenRise;                // a clock rise has followed the last start
    // addressing and page buffer
    logic [4:0] addrHi;            // high address byte, low five bits kept
    logic [ADDR_W-1:0] counter;    // word address counter
    logic [7:0] pageBase;          // page of the current write
    logic [7:0] pbData [PAGE_COUNT]; // page buffer bytes
    logic [PAGE_COUNT-1:0] pbValid;  // bytes to commit
    logic wrPending;               // write data awaits a stop
    // commit engine
    logic busy;                    // self-timed write running
    logic [TIMER_W-1:0] wrTimer;   // elapsed write cycle
    logic [5:0] feedIdx;           // page buffer slot being offered
    logic [2:0] paceCnt;           // array write pacing
    logic [7:0] mem [MEM_BYTES];   // the byte array
    // strobes
    logic sclRise, sclFall, startEvt, stopEvt;
    logic byteDone, ackEnd, hit, readLoad, wrByte;
    logic [7:0] memByte;
    tws_wr_entry_t feedEntry, drainEntry;
    logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady, commit, feeding;

    // device address word: type nibble and straps must match
    function automatic logic devMatch(input logic [7:0] w, input logic [2:0] s);
        devMatch = (w[7:4] == DEV_TYPE) && (w[3:1] == s);
    endfunction : devMatch

    // upper-quarter location while protection is on
    function automatic logic isProtected(input logic [ADDR_W-1:0] a, input logic wp);
        isProtected = wp && (a[ADDR_W-1:ADDR_W-2] == UPPER_QUAD);
    endfunction : isProtected

    // pin synchronisers; first stages feed only the second stages
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclS1 <= 1'b1;
            sclS2 <= 1'b1;
            sclD <= 1'b1;
            sdaS1 <= 1'b1;
            sdaS2 <= 1'b1;
            sdaD <= 1'b1;
            wpS1 <= 1'b0;
            wpS2 <= 1'b0;
            strapS1 <= 3'h0;
            strapS2 <= 3'h0;
        end
        else if (ce)
        begin
            sclS1 <= sclPin;
            sclS2 <= sclS1;
            sclD <= sclS2;
            sdaS1 <= sdaIn;
            sdaS2 <= sdaS1;
            sdaD <= sdaS2;
            wpS1 <= wpPin;
            wpS2 <= wpS1;
            strapS1 <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
            strapS2 <= strapS1;
        end
    end

    // bus events from the synchronised levels
    assign sclRise = sclS2 && !sclD;
    assign sclFall = !sclS2 && sclD;
    assign startEvt = sclS2 && sclD && !sdaS2 && sdaD;
    assign stopEvt = sclS2 && sclD && sdaS2 && !sdaD;
    // word-level strobes
    assign byteDone = sclFall && (bitCnt == LAST_DATA_BIT) && (state != ST_IDLE);
    assign ackEnd = sclFall && (bitCnt == ACK_BIT) && (state != ST_IDLE);
    assign hit = devMatch(shiftIn, strapS2) && !busy;
    assign readLoad = ackEnd && (((state == ST_DEV) && shiftIn[0]) ||
                      ((state == ST_RDAT) && masterAck));
    assign wrByte = byteDone && (state == ST_WDAT);
    assign memByte = mem[counter];
    assign sdaOut = 1'b0;
    assign sdaOe = sdaPull;

    // serial sequencer: word framing, ack and read data drive
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            shiftIn <= 8'h00;
            txByte <= 8'h00;
            masterAck <= 1'b0;
            sdaPull <= 1'b0;
            seenRise <= 1'b0;
        end
        else if (ce)
        begin
            if (startEvt)
            begin
                // start from any state re-frames the bus
                state <= ST_DEV;
                bitCnt <= 4'h0;
                sdaPull <= 1'b0;
                // the start's own clock fall must not count as a data bit
                seenRise <= 1'b0;
            end
            else if (stopEvt)
            begin
                // stop returns to standby
                state <= ST_IDLE;
                bitCnt <= 4'h0;
                sdaPull <= 1'b0;
            end
            else if (sclRise && state != ST_IDLE)
            begin
                // sample data on the rising edge, msb first
                seenRise <= 1'b1;
                if (bitCnt < ACK_BIT)
                begin
                    shiftIn <= {shiftIn[6:0], sdaS2};
                end
                else if (state == ST_RDAT)
                begin
                    masterAck <= !sdaS2;
                end
            end
            else if (sclFall && state != ST_IDLE && seenRise)
            begin
                // every drive change happens right after a falling edge
                if (bitCnt < LAST_DATA_BIT)
                begin
                    bitCnt <= bitCnt + 4'h1;
                    if (state == ST_RDAT)
                    begin
                        txByte <= {txByte[6:0], 1'b0};
                        sdaPull <= !txByte[6];
                    end
                end
                else if (bitCnt == LAST_DATA_BIT)
                begin
                    bitCnt <= ACK_BIT;
                    if (state == ST_RDAT)
                    begin
                        sdaPull <= 1'b0; // release for the master's ack
                    end
                    else if (state == ST_DEV && !hit)
                    begin
                        state <= ST_IDLE;
                        sdaPull <= 1'b0;
                    end
                    else
                    begin
                        sdaPull <= 1'b1;
                    end
                end
                else
                begin
                    // end of the ninth clock
                    bitCnt <= 4'h0;
                    sdaPull <= 1'b0;
                    unique case (state)
                        ST_DEV:
                        begin
                            if (shiftIn[0])
                            begin
                                state <= ST_RDAT;
                                txByte <= memByte;
                                sdaPull <= !memByte[7];
                            end
                            else
                            begin
                                state <= ST_AHI;
                            end
                        end
                        ST_AHI: state <= ST_ALO;
                        ST_ALO: state <= ST_WDAT;
                        ST_WDAT: state <= ST_WDAT;
                        ST_RDAT:
                        begin
                            if (masterAck)
                            begin
                                txByte <= memByte;
                                sdaPull <= !memByte[7];
                            end
                            else
                            begin
                                state <= ST_IDLE;
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // word address counter
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addrHi <= 5'h00;
            counter <= '0;
        end
        else if (ce)
        begin
            if (byteDone && state == ST_AHI)
            begin
                addrHi <= shiftIn[4:0];
            end
            else if (byteDone && state == ST_ALO)
            begin
                counter <= {addrHi, shiftIn};
            end
            else if (wrByte)
            begin
                // only the in-page bits advance
                counter[PAGE_W-1:0] <= counter[PAGE_W-1:0] + 5'h01;
            end
            else if (readLoad)
            begin
                // full-width advance wraps the whole array
                counter <= counter + 13'h0001;
            end
        end
    end

    // page buffer: gathers the bytes of one write sequence
    always_ff @(posedge core_clk)
    begin
        if (ce && wrByte && !isProtected({pageBase, counter[PAGE_W-1:0]}, wpS2))
        begin
            pbData[counter[PAGE_W-1:0]] <= shiftIn;
        end
    end

    // page buffer valid bits and pending write
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pageBase <= 8'h00;
            pbValid <= '0;
            wrPending <= 1'b0;
        end
        else if (ce)
        begin
            if (startEvt || stopEvt)
            begin
                // a stop hands the page to the commit engine
                wrPending <= 1'b0;
            end
            else if (byteDone && state == ST_ALO && !busy)
            begin
                pageBase <= {addrHi, shiftIn[7:PAGE_W]};
                pbValid <= '0;
            end
            else if (wrByte)
            begin
                wrPending <= 1'b1;
                if (!isProtected({pageBase, counter[PAGE_W-1:0]}, wpS2))
                begin
                    pbValid[counter[PAGE_W-1:0]] <= 1'b1;
                end
            end
        end
    end

    // commit feed: offers valid page bytes to the fifo
    assign feeding = busy && (feedIdx != PAGE_BYTES);
    assign fifoInValid = feeding && pbValid[feedIdx[PAGE_W-1:0]];
    assign feedEntry.addr = {pageBase, feedIdx[PAGE_W-1:0]};
    assign feedEntry.data = pbData[feedIdx[PAGE_W-1:0]];
    assign fifoOutReady = busy && (paceCnt == COMMIT_PACE_LAST);
    assign commit = fifoOutValid && fifoOutReady;

    tws_fifo #(
        .WIDTH($bits(tws_wr_entry_t)),
        .DEPTH(FIFO_DEPTH_P)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(feedEntry),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(drainEntry)
    );

    // self-timed write cycle and its feed and pacing
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            wrTimer <= '0;
            feedIdx <= 6'h00;
            paceCnt <= 3'h0;
        end
        else if (ce)
        begin
            if (!busy)
            begin
                if (stopEvt && wrPending)
                begin
                    busy <= 1'b1;
                    wrTimer <= '0;
                    feedIdx <= 6'h00;
                    paceCnt <= 3'h0;
                end
            end
            else
            begin
                // wrap at the pacing limit so one entry drains every four cycles
                paceCnt <= (paceCnt == COMMIT_PACE_LAST) ? 3'h0 : paceCnt + 3'h1;
                if (wrTimer != TIMER_W'(WR_CYCLES_P - 1))
                begin
                    wrTimer <= wrTimer + 1'b1;
                end
                // skip empty slots, wait on a full fifo
                if (feeding && (!pbValid[feedIdx[PAGE_W-1:0]] || fifoInReady))
                begin
                    feedIdx <= feedIdx + 6'h01;
                end
                // finish only when time is up and everything is stored
                if (wrTimer == TIMER_W'(WR_CYCLES_P - 1) && !feeding && !fifoOutValid)
                begin
                    busy <= 1'b0;
                end
            end
        end
    end

    // the byte array, written only by the commit engine
    always_ff @(posedge core_clk)
    begin
        if (ce && commit)
        begin
            mem[drainEntry.addr] <= drainEntry.data;
        end
    end

    assign writeBusy = busy;
    assign standby = (state == ST_IDLE) && !busy && !wrPending;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_devMiss;
        ce && byteDone && (state == ST_DEV) && !hit;
    endsequence
    sequence s_rxWord;
        ce && byteDone && (state inside {ST_AHI, ST_ALO, ST_WDAT});
    endsequence
    sequence s_protWrite;
        ce && wrByte && isProtected({pageBase, counter[PAGE_W-1:0]}, wpS2);
    endsequence

    property p_startToDev;
        ce && startEvt |=> (state == ST_DEV) && (bitCnt == 4'h0) && !sdaPull;
    endproperty
    a_startToDev: assert property (p_startToDev) else $error("start not taken");

    property p_stopToIdle;
        ce && stopEvt |=> (state == ST_IDLE) && !sdaPull;
    endproperty
    a_stopToIdle: assert property (p_stopToIdle) else $error("stop not taken");

    property p_bitRange;
        bitCnt <= ACK_BIT;
    endproperty
    a_bitRange: assert property (p_bitRange) else $error("bit count overran");

    property p_ackDrive;
        s_rxWord |=> sdaPull ##1 (sdaPull || (state == ST_IDLE) || !ce || ackEnd);
    endproperty
    a_ackDrive: assert property (p_ackDrive) else $error("word not acked");

    property p_devMiss;
        s_devMiss |=> (state == ST_IDLE) && !sdaPull;
    endproperty
    a_devMiss: assert property (p_devMiss) else $error("mismatch acked");

    property p_noAckBusy;
        busy |-> !sdaPull;
    endproperty
    a_noAckBusy: assert property (p_noAckBusy) else $error("bus driven while busy");

    property p_protect;
        s_protWrite |=> (pbValid == $past(pbValid)) && sdaPull;
    endproperty
    a_protect: assert property (p_protect) else $error("protected byte kept");

    property p_pageWrap;
        ce && wrByte |=> (counter[12:5] == $past(counter[12:5])) &&
            (counter[4:0] == $past(counter[4:0]) + 5'h01);
    endproperty
    a_pageWrap: assert property (p_pageWrap) else $error("page address wrong");

    property p_readAdvance;
        ce && readLoad |=> counter == $past(counter) + 13'h0001;
    endproperty
    a_readAdvance: assert property (p_readAdvance) else $error("read counter wrong");

    property p_driveWhileLow;
        ce && $changed(sdaPull) |-> !sclS2;
    endproperty
    a_driveWhileLow: assert property (p_driveWhileLow) else $error("drive with clock high");

    property p_stopStartsWrite;
        ce && stopEvt && wrPending && !busy |=> busy && (wrTimer == '0);
    endproperty
    a_stopStartsWrite: assert property (p_stopStartsWrite) else $error("write not started");
endmodule : tws_eeprom_slave

/* shared/tws_pkg.sv */
// constants, state codes and carriers for the two-wire memory target
// assumes a single core clock of 20 MHz that oversamples the serial clock
package tws_pkg;
    // device type pattern in the top nibble of the device address word
    localparam logic [3:0] DEV_TYPE = 4'ha;
    // word address and array geometry
    localparam int ADDR_W = 13;
    localparam int MEM_BYTES = 8192;
    localparam int PAGE_W = 5;
    localparam int PAGE_COUNT = 32;
    localparam logic [5:0] PAGE_BYTES = 6'h20;
    localparam logic [1:0] UPPER_QUAD = 2'h3;
    // bit counter values inside one nine-clock word
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    // self-timed write cycle
    localparam int CLK_HZ = 20000000;
    localparam int WR_TIME_MS = 5;
    localparam int WR_CYCLES = WR_TIME_MS * (CLK_HZ / 1000);
    // commit pacing: one array write every four cycles
    localparam logic [2:0] COMMIT_PACE_LAST = 3'h3;
    // commit fifo depth
    localparam int FIFO_DEPTH = 16;

    // bus-side sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, // standby, waiting for a start
        ST_DEV = 6'h02,  // receiving device address word
        ST_AHI = 6'h04,  // receiving high word-address byte
        ST_ALO = 6'h08,  // receiving low word-address byte
        ST_WDAT = 6'h10, // receiving write data
        ST_RDAT = 6'h20  // sending read data
    } tws_state_t;

    // one pending array write
    typedef struct packed {
        logic [ADDR_W-1:0] addr; // byte location
        logic [7:0] data;        // byte value
    } tws_wr_entry_t;
endpackage : tws_pkg

/* bench/tws_ctrl_model.sv */
// two-wire bus controller model: start, stop, byte write, byte read
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ns
module tws_ctrl_model (
    output logic scl,     // serial clock, stands high between frames
    output logic sdaLow,  // high while the controller pulls data low
    input wire logic sda  // resolved data wire
);
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sdaLow = 1'b0;
        #250 scl = 1'b1;
        #250 sdaLow = 1'b1;
        #250 scl = 1'b0;
    endtask : start
    // stop: data rises while the clock is high
    task automatic stop();
        sdaLow = 1'b1;
        #250 scl = 1'b1;
        #250 sdaLow = 1'b0;
        #250;
    endtask : stop
    // one clock: data moves only while the clock is low, low 250 ns, high 150 ns
    task automatic bit_io(input logic b, output logic r);
        #50 sdaLow = ~b;
        #200 scl = 1'b1;
        #140 r = sda;
        #10 scl = 1'b0;
    endtask : bit_io
    // eight bits msb first, then the ninth clock samples acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put_byte
    // read a byte, then acknowledge to continue or withhold it to end
    task automatic get_byte(input logic mack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(~mack, r);
    endtask : get_byte
endmodule : tws_ctrl_model

/* bench/test_two_wire_eeprom_slave.sv */
// self-checking bench for the memory target with a bus controller model
// assumes a pull-up on the data wire and a shortened write cycle
`timescale 1ns/1ns
module test_two_wire_eeprom_slave;
    import tws_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b0, wpPin = 1'b0;
    logic scl, sdaLow, sdaOut, sdaOe, standby, writeBusy, ack;
    logic [2:0] strap = 3'h0; // select straps, randomised
    logic [31:0] lfsr = 32'h220c4066;
    logic [7:0] refMem [0:MEM_BYTES-1]; // expected array contents
    logic [7:0] rd;
    logic [12:0] cnt; // expected address counter
    int failures = 0, n_compared = 0;
    wire logic sda = ~sdaLow & (sdaOe ? sdaOut : 1'b1); // open drain with pull-up
    always #25 core_clk = ~core_clk;
    tws_eeprom_slave #(.WR_CYCLES_P(200), .FIFO_DEPTH_P(16)) u_tws_eeprom_slave (
        .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .sclPin(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .wpPin(wpPin), .select_strap_bit2(strap[2]),
        .select_strap_bit1(strap[1]), .select_strap_bit0(strap[0]),
        .standby(standby), .writeBusy(writeBusy));
    tws_ctrl_model u_tws_ctrl_model (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    // random source
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand
    // write slot: low five bits wrap inside the page
    function automatic logic [12:0] page_slot(input logic [12:0] b, input int i);
        return {b[12:5], b[4:0] + 5'(i)};
    endfunction : page_slot
    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // send a byte and compare the acknowledge
    task automatic send(input logic [7:0] b, input logic exp);
        u_tws_ctrl_model.put_byte(b, ack);
        check({7'h0, ack}, {7'h0, exp});
    endtask : send
    // dummy write with the ignored top bits set
    task automatic set_addr(input logic [12:0] a);
        u_tws_ctrl_model.start();
        send({DEV_TYPE, strap, 1'b0}, 1'b1);
        send({3'h7, a[12:8]}, 1'b1);
        send(a[7:0], 1'b1);
    endtask : set_addr
    // page write of n random bytes, then poll until acknowledged
    task automatic write_page(input logic [12:0] b, input int n);
        set_addr(b);
        for (int i = 0; i < n; i++)
        begin
            lfsr = next_rand(lfsr);
            send(lfsr[7:0], 1'b1);
            if (!(wpPin && b[12:11] == UPPER_QUAD))
                refMem[page_slot(b, i)] = lfsr[7:0];
        end
        u_tws_ctrl_model.stop();
        check({7'h0, writeBusy}, 8'h1);
        check({7'h0, standby}, 8'h0);
        u_tws_ctrl_model.start();
        send({DEV_TYPE, strap, 1'b0}, 1'b0);
        for (int t = 0; t < 20 && !ack; t++)
        begin
            u_tws_ctrl_model.start();
            u_tws_ctrl_model.put_byte({DEV_TYPE, strap, 1'b0}, ack);
        end
        u_tws_ctrl_model.stop();
        check({7'h0, ack}, 8'h1);
        check({7'h0, standby}, 8'h1);
    endtask : write_page
    // read n bytes from the counter, acknowledging all but the last
    task automatic read_seq(input int n);
        u_tws_ctrl_model.start();
        send({DEV_TYPE, strap, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            u_tws_ctrl_model.get_byte(i < n - 1, rd);
            check(rd, refMem[cnt]);
            cnt++;
        end
        u_tws_ctrl_model.stop();
    endtask : read_seq
    // verdict and end of run
    task automatic complete_run();
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // watchdog
    initial
    begin
        #3000000;
        failures++;
        complete_run();
    end
    // main sequence
    initial
    begin
        strap = lfsr[2:0];
        repeat (16) @(posedge core_clk);
        #5 rst_n = 1'b1;
        ce = 1'b1;
        repeat (4) @(posedge core_clk);
        #5;
        check({7'h0, standby}, 8'h1);
        u_tws_ctrl_model.start();
        send({DEV_TYPE, ~strap, 1'b0}, 1'b0);
        u_tws_ctrl_model.start();
        send({4'h5, strap, 1'b1}, 1'b0);
        u_tws_ctrl_model.stop();
        write_page(13'h0000, 34);
        write_page(13'h1ffe, 2);
        set_addr(13'h0000);
        cnt = 13'h0000;
        read_seq(32);
        set_addr(13'h1ffe);
        cnt = 13'h1ffe;
        read_seq(3);
        read_seq(1);
        @(posedge core_clk) #5 wpPin = 1'b1;
        write_page(13'h1ffe, 2);
        write_page(13'h0005, 1);
        set_addr(13'h1ffe);
        cnt = 13'h1ffe;
        read_seq(8);
        complete_run();
    end
endmodule : test_two_wire_eeprom_slave
